// >>> hw/dio_defines.svh
// constants of the drive i/o status and limit select block
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// parameter addresses on the documented access port
`define DIO_ADDR_IO_STATE     16'h0802
`define DIO_ADDR_LIM_SEL      16'h1216
`define DIO_ADDR_CUR_SCALE    16'h1218
`define DIO_ADDR_SPD_SCALE    16'h121A

// reset values
`define DIO_RST_LIM_SEL       16'h0000
`define DIO_RST_CUR_SCALE     16'h012C
`define DIO_RST_SPD_SCALE     16'h0BB8

// legal ranges of written values
`define DIO_LIM_SEL_MAX       16'h0002
`define DIO_CUR_SCALE_MAX     16'h0BB8
`define DIO_SPD_SCALE_MIN     16'h01F4
`define DIO_SPD_SCALE_MAX     16'h7530

// analogue full scale in mV and speed floor in rpm
`define DIO_FULL_SCALE_MV     16'h2710
`define DIO_SPEED_FLOOR_RPM   16'h0064

// error codes of the safe-off monitor
`define DIO_ERR_SAFE_OFF      16'h0514
`define DIO_ERR_SAFE_WIRING   16'h0515

// i/o state word field positions
`define DIO_BIT_FAULT_FREE    8
`define DIO_BIT_RUNNING       9
`define DIO_BIT_FORCE_EN      15

// timing: clock period and safe-off agreement window, both in ns
`define DIO_CLK_PERIOD_NS     4
`define DIO_SOF_WINDOW_NS     1000
// longest time rounds down, never below one cycle
`define DIO_SOF_WINDOW_CYC    ((`DIO_SOF_WINDOW_NS / `DIO_CLK_PERIOD_NS) < 1 ? 1 : \
                               (`DIO_SOF_WINDOW_NS / `DIO_CLK_PERIOD_NS))

`endif

// >>> hw/dio_pkg.sv
// types of the drive i/o status and limit select block
package dio_pkg;

  typedef enum logic [1:0] {
    DIO_LIM_NONE,
    DIO_LIM_CURRENT,
    DIO_LIM_SPEED
  } dio_lim_mode_t;

  typedef enum logic [1:0] {
    DIO_SOF_ON,
    DIO_SOF_WAIT,
    DIO_SOF_OFF
  } dio_sof_state_t;

endpackage : dio_pkg

// >>> hw/dio_sof_if.sv
// carrier between the top and the safe-off monitor
interface dio_sof_if;
  logic        a_active;
  logic        b_active;
  logic        clear;
  logic        amp_off;
  logic        err_valid;
  logic [15:0] err_code;

  modport mon (
    input  a_active,
    input  b_active,
    input  clear,
    output amp_off,
    output err_valid,
    output err_code
  );

  modport top (
    output a_active,
    output b_active,
    output clear,
    input  amp_off,
    input  err_valid,
    input  err_code
  );
endinterface : dio_sof_if

// >>> hw/dio_sof_mon.sv
// two-channel safe-off monitor with agreement window
`include "dio_defines.svh"

module dio_sof_mon #(
  parameter int WINDOW_CYC = `DIO_SOF_WINDOW_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  dio_sof_if.mon    sof
);

  dio_pkg::dio_sof_state_t state_q, state_d;
  logic [15:0]             cnt_q, cnt_d;
  logic [15:0]             code_q, code_d;
  logic                    valid_q, valid_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: a lone channel drop starts the window, both low cuts power
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    code_d  = code_q;
    valid_d = valid_q;
    unique case (state_q)
      dio_pkg::DIO_SOF_ON: begin
        cnt_d = 16'h0000;
        if (!sof.a_active && !sof.b_active) begin
          state_d = dio_pkg::DIO_SOF_OFF;          // see R14
          code_d  = `DIO_ERR_SAFE_OFF;
          valid_d = 1'b1;
        end else if (sof.a_active != sof.b_active) begin
          state_d = dio_pkg::DIO_SOF_WAIT;         // see R18
          cnt_d   = 16'h0001;
        end
      end
      dio_pkg::DIO_SOF_WAIT: begin
        cnt_d = cnt_q + 16'h0001;
        if (!sof.a_active && !sof.b_active) begin
          state_d = dio_pkg::DIO_SOF_OFF;          // see R18
          code_d  = `DIO_ERR_SAFE_OFF;
          valid_d = 1'b1;
        end else if (sof.a_active && sof.b_active) begin
          state_d = dio_pkg::DIO_SOF_ON;           // bounce settled in time
        end else if (cnt_q >= 16'(WINDOW_CYC)) begin
          state_d = dio_pkg::DIO_SOF_OFF;          // see R15
          code_d  = `DIO_ERR_SAFE_WIRING;
          valid_d = 1'b1;
        end
      end
      dio_pkg::DIO_SOF_OFF: begin
        // restart only on request and with both channels back, never by itself
        if (sof.clear && sof.a_active && sof.b_active) begin
          state_d = dio_pkg::DIO_SOF_ON;
          code_d  = 16'h0000;
          valid_d = 1'b0;
        end
      end
      default: state_d = dio_pkg::DIO_SOF_OFF;     // illegal code: fail safe
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= dio_pkg::DIO_SOF_ON;
      cnt_q   <= 16'h0000;
      code_q  <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      code_q  <= code_d;
      valid_q <= valid_d;
    end
  end

  // power stage is held off for the whole error state
  assign sof.amp_off   = (state_q == dio_pkg::DIO_SOF_OFF);  // see R14
  assign sof.err_valid = valid_q;
  assign sof.err_code  = code_q;

endmodule : dio_sof_mon

// >>> hw/dio_top.sv
// drive i/o status word, limit source select and switch supervision
//
// Contract
// R1 - selector: 0 none, 1 current, 2 speed
// R2 - 10 V gives scale, capped by peak currents
// R3 - current scale 0 to 3000, 0.01 A
// R4 - speed limit never below 100 rpm; here a max_speed_i below 100 wins
// R5 - speed limit clamped to configured maximum speed
// R6 - state word: inputs 0-7, outputs 8-9
// R7 - local mode input bit assignment
// R8 - fieldbus mode input bit assignment
// R9 - bit 6 enables only local with pulse/direction
// R10 - fieldbus reads and modifies, display only reads
// R11 - triggered limit or reference switch raises error
// R12 - per-switch enable and selectable active level
// R13 - integrator prefers active-low switches for wire-break
// R14 - both safe-off inactive: power off, code 1300
// R15 - safe-off channels disagreeing: code 1301
// R16 - integrator keeps auto enable at power-up off
// R17 - unused safe-off: both inputs held at 24 V
// R18 - mismatch tolerated within fixed debounce window
// R19 - reset values 0, 300, 3000; word shows pins
`include "dio_defines.svh"

module dio_top #(
  parameter int SOF_WINDOW_CYC = `DIO_SOF_WINDOW_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // 24 V input pins, bit order of the state word, 1 = 24 V present
  input  wire logic [7:0]         io_pin_i,
  // configuration levels from the drive controller
  input  wire logic               local_io_command_mode_i,
  input  wire logic               pd_input_select_i,
  input  wire logic [2:0]         switch_enable_i,
  input  wire logic [2:0]         switch_active_high_i,
  input  wire logic [15:0]        motor_peak_current_i,
  input  wire logic [15:0]        amplifier_peak_current_i,
  input  wire logic [15:0]        max_speed_i,
  input  wire logic signed [15:0] second_analog_input_mv_i,
  input  wire logic               drive_fault_i,
  input  wire logic               drive_running_i,
  input  wire logic               fault_clear_i,
  // parameter access port
  input  wire logic               par_rd_i,
  input  wire logic               par_wr_i,
  input  wire logic               par_from_fieldbus_i,
  input  wire logic [15:0]        par_addr_i,
  input  wire logic [15:0]        par_wdata_i,
  output logic      [15:0]        par_rdata_o,
  output logic                    par_ack_o,
  output logic                    par_err_o,
  // outputs to the controllers and the power stage
  output logic      [15:0]        current_limit_o,
  output logic                    current_limit_en_o,
  output logic      [15:0]        speed_limit_o,
  output logic                    speed_limit_en_o,
  output logic                    io_enable_o,
  output logic                    io_halt_o,
  output logic                    fault_free_output_o,
  output logic                    drive_running_output_o,
  output logic      [2:0]         switch_error_o,
  output logic                    amp_off_o,
  output logic                    error_valid_o,
  output logic      [15:0]        error_code_o
);

  ////////////////////////////////////////////////////////////////////////////
  // scale an analogue voltage against a 10 V full-scale value
  function automatic logic [15:0] dio_scale(input logic [15:0]        full,
                                            input logic signed [15:0] mv);
    logic [15:0] mv_c;
    logic [31:0] prod;
    mv_c = 16'h0000;
    if (mv > $signed(16'h0000)) begin
      mv_c = (mv > $signed(`DIO_FULL_SCALE_MV)) ? `DIO_FULL_SCALE_MV : 16'(mv);
    end
    prod = 32'(full) * 32'(mv_c);
    return 16'(prod / 32'(`DIO_FULL_SCALE_MV));
  endfunction : dio_scale

  function automatic logic [15:0] dio_min(input logic [15:0] x, input logic [15:0] y);
    return (x < y) ? x : y;
  endfunction : dio_min

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: second stage is the only reader of the first
  // they run through reset, so no false safe-off trip follows its release
  logic [7:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge clk_i) begin
    pin_s1_q <= io_pin_i;
    pin_s2_q <= pin_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter registers and access port
  dio_pkg::dio_lim_mode_t lim_sel_q, lim_sel_d;
  logic [15:0] cur_scale_q, cur_scale_d;
  logic [15:0] spd_scale_q, spd_scale_d;
  logic [1:0]  out_force_q, out_force_d;
  logic        force_en_q, force_en_d;
  logic [15:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        err_q, err_d;
  logic [15:0] io_word;

  // a write out of range or from the display leaves the register untouched
  always_comb begin
    lim_sel_d   = lim_sel_q;
    cur_scale_d = cur_scale_q;
    spd_scale_d = spd_scale_q;
    out_force_d = out_force_q;
    force_en_d  = force_en_q;
    rdata_d     = rdata_q;
    ack_d       = par_rd_i || par_wr_i;
    err_d       = 1'b0;
    if (par_wr_i) begin
      if (!par_from_fieldbus_i) begin
        err_d = 1'b1;                                        // see R10
      end else begin
        unique case (par_addr_i)
          `DIO_ADDR_IO_STATE: begin
            out_force_d = par_wdata_i[`DIO_BIT_RUNNING:`DIO_BIT_FAULT_FREE];  // see R10
            force_en_d  = par_wdata_i[`DIO_BIT_FORCE_EN];
          end
          `DIO_ADDR_LIM_SEL: begin
            if (par_wdata_i <= `DIO_LIM_SEL_MAX) begin         // see R1
              lim_sel_d = dio_pkg::dio_lim_mode_t'(par_wdata_i[1:0]);
            end else begin
              err_d = 1'b1;
            end
          end
          `DIO_ADDR_CUR_SCALE: begin
            if (par_wdata_i <= `DIO_CUR_SCALE_MAX) begin       // see R3
              cur_scale_d = par_wdata_i;
            end else begin
              err_d = 1'b1;
            end
          end
          `DIO_ADDR_SPD_SCALE: begin
            if (par_wdata_i >= `DIO_SPD_SCALE_MIN && par_wdata_i <= `DIO_SPD_SCALE_MAX) begin
              spd_scale_d = par_wdata_i;
            end else begin
              err_d = 1'b1;
            end
          end
          default: err_d = 1'b1;                             // unmapped address
        endcase
      end
    end else if (par_rd_i) begin
      // both parties may read; unmapped reads return zero and flag an error
      unique case (par_addr_i)
        `DIO_ADDR_IO_STATE:  rdata_d = io_word;              // see R10
        `DIO_ADDR_LIM_SEL:   rdata_d = {14'h0000, lim_sel_q};
        `DIO_ADDR_CUR_SCALE: rdata_d = cur_scale_q;
        `DIO_ADDR_SPD_SCALE: rdata_d = spd_scale_q;
        default: begin
          rdata_d = 16'h0000;
          err_d   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_sel_q   <= dio_pkg::dio_lim_mode_t'(`DIO_RST_LIM_SEL);  // see R19
      cur_scale_q <= `DIO_RST_CUR_SCALE;                           // see R19
      spd_scale_q <= `DIO_RST_SPD_SCALE;                           // see R19
      out_force_q <= 2'b00;
      force_en_q  <= 1'b0;
      rdata_q     <= 16'h0000;
      ack_q       <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      lim_sel_q   <= lim_sel_d;
      cur_scale_q <= cur_scale_d;
      spd_scale_q <= spd_scale_d;
      out_force_q <= out_force_d;
      force_en_q  <= force_en_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      err_q       <= err_d;
    end
  end

  assign par_rdata_o = rdata_q;
  assign par_ack_o   = ack_q;
  assign par_err_o   = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // state word: meaning of the input bits follows the command source
  logic [7:0] in_bits;
  logic       fault_out, run_out;

  always_comb begin
    if (local_io_command_mode_i) begin
      // bit 0 unused, 1 clear, 2 enable, 3 halt, 4/5 safe-off, 6 alt enable
      in_bits = {1'b0, pd_input_select_i & pin_s2_q[6], pin_s2_q[5:1], 1'b0};  // see R7
    end else begin
      // bit 0 ref, 1 neg end/capture 2, 2 pos end/capture 1, 3 halt, 4/5 safe-off
      in_bits = {2'b00, pin_s2_q[5:0]};                                         // see R8
    end
  end

  // outputs may be overridden by the fieldbus for commissioning
  assign fault_out = force_en_q ? out_force_q[0] : !drive_fault_i;     // see R10
  assign run_out   = force_en_q ? out_force_q[1] : drive_running_i;
  assign io_word   = {6'h00, run_out, fault_out, in_bits};             // see R6 R19

  ////////////////////////////////////////////////////////////////////////////
  // enable and halt; bit 6 counts only in local pulse/direction mode
  logic enable_d, enable_q, halt_d, halt_q, fo_q, run_q;

  always_comb begin
    enable_d = local_io_command_mode_i &&
               (pin_s2_q[2] || (pd_input_select_i && pin_s2_q[6]));    // see R9
    halt_d   = pin_s2_q[3];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
      halt_q   <= 1'b0;
      fo_q     <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      enable_q <= enable_d;
      halt_q   <= halt_d;
      fo_q     <= fault_out;
      run_q    <= run_out;
    end
  end

  assign io_enable_o            = enable_q;
  assign io_halt_o              = halt_q;
  assign fault_free_output_o    = fo_q;    // see R6
  assign drive_running_output_o = run_q;   // see R6

  ////////////////////////////////////////////////////////////////////////////
  // limit and reference switches: sticky flags, an arriving event beats clear
  logic [2:0] sw_hit;
  logic [2:0] sw_err_q, sw_err_d;
  logic       clr_pin_q;
  logic       err_clear;

  // pins: 0 ref, 1 negative end, 2 positive end; only wired in fieldbus mode
  assign sw_hit = {3{!local_io_command_mode_i}} & switch_enable_i &
                  ~(pin_s2_q[2:0] ^ switch_active_high_i);             // see R12
  // error clear: fieldbus request or rising edge of the local clear input
  assign err_clear = fault_clear_i ||
                     (local_io_command_mode_i && pin_s2_q[1] && !clr_pin_q);

  always_comb begin
    sw_err_d = (err_clear ? 3'b000 : sw_err_q) | sw_hit;               // see R11
  end

  // edge history follows the pin through reset: no false clear edge after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_err_q <= 3'b000;
    end else begin
      sw_err_q <= sw_err_d;
    end
    clr_pin_q <= pin_s2_q[1];
  end

  assign switch_error_o = sw_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // safe-off monitor
  dio_sof_if sof ();

  assign sof.a_active = pin_s2_q[5];
  assign sof.b_active = pin_s2_q[4];
  assign sof.clear    = err_clear;

  dio_sof_mon #(
    .WINDOW_CYC (SOF_WINDOW_CYC)
  ) u_sof_mon (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sof   (sof.mon)
  );

  assign amp_off_o     = sof.amp_off;     // see R14
  assign error_valid_o = sof.err_valid;   // see R14 R15
  assign error_code_o  = sof.err_code;

  ////////////////////////////////////////////////////////////////////////////
  // limit computation, registered so the outputs come from flip-flops
  logic [15:0] cur_lim_d, cur_lim_q, spd_lim_d, spd_lim_q, raw_spd;
  logic        cur_en_d, cur_en_q, spd_en_d, spd_en_q;

  always_comb begin
    // scaled value capped by the smaller of motor and amplifier peak
    cur_lim_d = dio_min(dio_scale(cur_scale_q, second_analog_input_mv_i),
                        dio_min(motor_peak_current_i, amplifier_peak_current_i));  // see R2
    raw_spd   = dio_scale(spd_scale_q, second_analog_input_mv_i);
    // floor first, then the maximum speed wins if it is set lower
    spd_lim_d = dio_min((raw_spd < `DIO_SPEED_FLOOR_RPM) ? `DIO_SPEED_FLOOR_RPM : raw_spd,
                        max_speed_i);                                  // see R4 R5
    cur_en_d  = (lim_sel_q == dio_pkg::DIO_LIM_CURRENT);               // see R1
    spd_en_d  = (lim_sel_q == dio_pkg::DIO_LIM_SPEED);                 // see R1
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_lim_q <= 16'h0000;
      spd_lim_q <= 16'h0000;
      cur_en_q  <= 1'b0;
      spd_en_q  <= 1'b0;
    end else begin
      cur_lim_q <= cur_lim_d;
      spd_lim_q <= spd_lim_d;
      cur_en_q  <= cur_en_d;
      spd_en_q  <= spd_en_d;
    end
  end

  assign current_limit_o    = cur_lim_q;
  assign current_limit_en_o = cur_en_q;
  assign speed_limit_o      = spd_lim_q;
  assign speed_limit_en_o   = spd_en_q;

endmodule : dio_top

// >>> testbench/dio_top_monitor.sv
// assertions on the ports of the drive i/o block
module dio_top_monitor #(
  parameter int SOF_WINDOW_CYC = 250
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  io_pin_i,
  input wire logic        local_io_command_mode_i,
  input wire logic        pd_input_select_i,
  input wire logic [2:0]  switch_enable_i,
  input wire logic [2:0]  switch_active_high_i,
  input wire logic [15:0] motor_peak_current_i,
  input wire logic [15:0] amplifier_peak_current_i,
  input wire logic [15:0] max_speed_i,
  input wire logic        par_rd_i,
  input wire logic        par_wr_i,
  input wire logic        par_from_fieldbus_i,
  input wire logic        par_ack_o,
  input wire logic        par_err_o,
  input wire logic [15:0] current_limit_o,
  input wire logic [15:0] speed_limit_o,
  input wire logic        speed_limit_en_o,
  input wire logic        io_enable_o,
  input wire logic        io_halt_o,
  input wire logic [2:0]  switch_error_o,
  input wire logic        amp_off_o,
  input wire logic        error_valid_o,
  input wire logic [15:0] error_code_o
);
  logic [15:0] mis_q, mis_d;
  logic [2:0]  hit_w;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // enabled switches at their active level
  assign hit_w = switch_enable_i & ~(io_pin_i[2:0] ^ switch_active_high_i);

  // saturating run length of a safe-off split
  always_comb begin
    mis_d = 16'h0000;
    if (^io_pin_i[5:4]) begin
      mis_d = (mis_q == 16'hFFFF) ? mis_q : mis_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mis_q <= 16'h0000;
    end else begin
      mis_q <= mis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_ack;
    par_ack_o == $past(par_rd_i || par_wr_i);
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_disp_wr;
    par_wr_i && !par_from_fieldbus_i |=> par_ack_o && par_err_o;
  endproperty
  a_disp_wr: assert property (p_disp_wr) else $error("display wrote");
  property p_halt;
    $stable(io_pin_i)[*6] |-> io_halt_o == io_pin_i[3];
  endproperty
  a_halt: assert property (p_halt) else $error("bad halt");
  property p_enable;
    $stable({io_pin_i, local_io_command_mode_i, pd_input_select_i})[*6] |->
      io_enable_o == (local_io_command_mode_i && (io_pin_i[2] || (pd_input_select_i && io_pin_i[6])));
  endproperty
  a_enable: assert property (p_enable) else $error("bad enable");
  property p_switch;
    !local_io_command_mode_i &&
      $stable({io_pin_i, local_io_command_mode_i, switch_enable_i, switch_active_high_i})[*6]
      |-> (switch_error_o & hit_w) == hit_w;
  endproperty
  a_switch: assert property (p_switch) else $error("switch missed");
  property p_sof_off;
    !error_valid_o && $past(io_pin_i[5:4]) == 2'b11 && io_pin_i[5:4] == 2'b00 |->
      ##[1:6] (amp_off_o && error_valid_o && error_code_o == 16'h0514);
  endproperty
  a_sof_off: assert property (p_sof_off) else $error("no safe-off stop");
  property p_sof_wire;
    mis_q == 16'(SOF_WINDOW_CYC + 6) && error_code_o != 16'h0514 |->
      error_valid_o && error_code_o == 16'h0515;
  endproperty
  a_sof_wire: assert property (p_sof_wire) else $error("no wiring fault");
  property p_cur_cap;
    current_limit_o <= $past(motor_peak_current_i) &&
      current_limit_o <= $past(amplifier_peak_current_i);
  endproperty
  a_cur_cap: assert property (p_cur_cap) else $error("current over peak");
  property p_spd;
    speed_limit_en_o |-> speed_limit_o <= $past(max_speed_i) &&
      (speed_limit_o >= 16'h0064 || speed_limit_o == $past(max_speed_i));
  endproperty
  a_spd: assert property (p_spd) else $error("bad speed limit");
endmodule : dio_top_monitor

// >>> testbench/dio_pin_model.sv
// far-side model: 24 V pins, channel b of the safe-off pair may lag
module dio_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  input  wire logic [3:0] lag_b_i,
  output logic      [7:0] io_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hist_q;

  // unused safe-off pair sits at 24 V
  initial io_pin_o = 8'h37;
  initial hist_q = 16'hFFFF;

  // switches idle high: a broken wire reads as a hit
  always @(posedge clk_i) begin
    hist_q <= {hist_q[14:0], want_i[4]};
    io_pin_o <= {want_i[7:5], (lag_b_i == 4'h0) ? want_i[4] : hist_q[lag_b_i - 4'h1], want_i[3:0]};
  end
endmodule : dio_pin_model

// >>> testbench/dio_top_tb.sv
// bench of the drive i/o block
module dio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 4;
  logic clk_i, rst_i, local_io_command_mode_i, pd_input_select_i, drive_fault_i;
  logic drive_running_i, fault_clear_i, par_rd_i, par_wr_i, par_from_fieldbus_i;
  logic [2:0]  switch_enable_i, switch_active_high_i, switch_error_o;
  logic [15:0] motor_peak_current_i, amplifier_peak_current_i, max_speed_i, par_addr_i;
  logic [15:0] par_wdata_i, par_rdata_o, current_limit_o, speed_limit_o, error_code_o;
  logic signed [15:0] second_analog_input_mv_i;
  logic [7:0]  io_pin_i, want;
  logic [3:0]  lag_b;
  logic par_ack_o, par_err_o, current_limit_en_o, speed_limit_en_o, io_enable_o, io_halt_o;
  logic fault_free_output_o, drive_running_output_o, amp_off_o, error_valid_o;
  int n_errors = 0;
  int checks_done = 0;
  logic [15:0] r_adr [3] = '{16'h1216, 16'h1218, 16'h121A};
  logic [15:0] r_val [3] = '{16'h0000, 16'h012C, 16'h0BB8};
  logic [1:0]  t_mode [4] = '{2'b10, 2'b11, 2'b10, 2'b01};
  logic [7:0]  t_pin [4] = '{8'hFF, 8'hFB, 8'hFB, 8'hFF};
  logic [15:0] t_word [4] = '{16'h033E, 16'h037A, 16'h033A, 16'h033F};
  logic        t_en [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  dio_top #(.SOF_WINDOW_CYC(WIN)) dio_top_i (.*);
  dio_pin_model dio_pin_model_i (.clk_i(clk_i), .want_i(want), .lag_b_i(lag_b),
                                 .io_pin_o(io_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // answer stands the cycle after the taking edge
  task automatic acc(input logic wr, fb, input logic [15:0] adr, wd, exp_d, input logic exp_e);
    @(posedge clk_i);
    par_wr_i <= wr;
    par_rd_i <= !wr;
    par_from_fieldbus_i <= fb;
    par_addr_i <= adr;
    par_wdata_i <= wd;
    @(posedge clk_i);
    par_wr_i <= 1'b0;
    par_rd_i <= 1'b0;
    @(negedge clk_i);
    chk("ack", 16'h0001, 16'(par_ack_o));
    chk("err", 16'(exp_e), 16'(par_err_o));
    if (!wr) chk("rdata", exp_d, par_rdata_o);
  endtask : acc

  task automatic clr();
    @(posedge clk_i);
    fault_clear_i <= 1'b1;
    @(posedge clk_i);
    fault_clear_i <= 1'b0;
    settle(2);
  endtask : clr

  task automatic pins(input logic [7:0] p, input int n);
    @(posedge clk_i);
    want <= p;
    settle(n);
  endtask : pins

  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // a hang fails
  initial begin
    repeat (6000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {local_io_command_mode_i, pd_input_select_i, drive_fault_i, fault_clear_i} = 4'h8;
    {par_rd_i, par_wr_i, par_from_fieldbus_i, drive_running_i} = 4'h1;
    {switch_enable_i, switch_active_high_i, lag_b} = 10'h000;
    {motor_peak_current_i, amplifier_peak_current_i} = {16'h0FA0, 16'h0FA0};
    {max_speed_i, second_analog_input_mv_i} = {16'h0BB8, 16'h0000};
    {par_addr_i, par_wdata_i, want} = {16'h0000, 16'h0000, 8'h37};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) acc('0, '1, r_adr[i], '0, r_val[i], '0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {local_io_command_mode_i, pd_input_select_i} <= t_mode[i];
      pins(t_pin[i], 6);
      acc('0, '0, 16'h0802, '0, t_word[i], '0);
      chk("io_enable", 16'(t_en[i]), 16'(io_enable_o));
    end
    pins(8'h37, 6);
    acc('1, '0, 16'h1216, 16'h0002, '0, '1);
    acc('1, '0, 16'h0802, 16'h8300, '0, '1);
    acc('1, '1, 16'h1216, 16'h0003, '0, '1);
    acc('1, '1, 16'h1218, 16'h0BB9, '0, '1);
    acc('1, '1, 16'h1218, 16'h0BB8, '0, '0);
    acc('0, '1, 16'h1234, '0, '0, '1);
    acc('0, '1, 16'h1216, '0, '0, '0);
    acc('0, '0, 16'h1218, '0, 16'h0BB8, '0);
    // current limits
    acc('1, '1, 16'h1216, 16'h0001, '0, '0);
    @(posedge clk_i);
    {second_analog_input_mv_i, motor_peak_current_i} <= {16'h2710, 16'h07D0};
    settle(3);
    chk("cur_lim", 16'h07D0, current_limit_o);
    chk("cur_en", 16'h0001, 16'(current_limit_en_o));
    chk("spd_en", '0, 16'(speed_limit_en_o));
    @(posedge clk_i);
    {second_analog_input_mv_i, motor_peak_current_i} <= {16'h1388, 16'h0FA0};
    settle(3);
    chk("cur_lim", 16'h05DC, current_limit_o);
    @(posedge clk_i);
    second_analog_input_mv_i <= 16'h7530;
    settle(3);
    chk("cur_lim", 16'h0BB8, current_limit_o);
    // speed floor, then ceiling
    acc('1, '1, 16'h1216, 16'h0002, '0, '0);
    @(posedge clk_i);
    second_analog_input_mv_i <= 16'h0064;
    settle(3);
    chk("spd_lim", 16'h0064, speed_limit_o);
    @(posedge clk_i);
    {second_analog_input_mv_i, max_speed_i} <= {16'h2710, 16'h07D0};
    settle(3);
    chk("spd_lim", 16'h07D0, speed_limit_o);
    acc('1, '1, 16'h1216, '0, '0, '0);
    settle(2);
    chk("en_none", '0, 16'({current_limit_en_o, speed_limit_en_o}));
    // forced outputs, then release
    acc('1, '1, 16'h0802, 16'h8100, '0, '0);
    settle(2);
    chk("forced", 16'h0001, 16'({drive_running_output_o, fault_free_output_o}));
    acc('1, '1, 16'h0802, '0, '0, '0);
    @(posedge clk_i);
    drive_fault_i <= 1'b1;
    settle(3);
    chk("outputs", 16'h0002, 16'({drive_running_output_o, fault_free_output_o}));
    // fieldbus switches, active low, then active high and disabled
    @(posedge clk_i);
    {local_io_command_mode_i, switch_enable_i} <= {1'b0, 3'b111};
    pins(8'h35, 6);
    chk("sw_err", 16'h0002, 16'(switch_error_o));
    pins(8'h37, 2);
    clr();
    chk("sw_err", '0, 16'(switch_error_o));
    @(posedge clk_i);
    switch_active_high_i <= 3'b001;
    settle(6);
    chk("sw_err", 16'h0001, 16'(switch_error_o));
    @(posedge clk_i);
    {switch_active_high_i, switch_enable_i} <= {3'b000, 3'b101};
    clr();
    pins(8'h35, 6);
    chk("sw_err", '0, 16'(switch_error_o));
    // safe-off: together, skewed, glitch, lasting split
    pins(8'h07, 8);
    chk("amp_off", 16'h0001, 16'(amp_off_o));
    chk("code", 16'h0514, error_code_o);
    pins(8'h37, 2);
    clr();
    chk("valid", '0, 16'({amp_off_o, error_valid_o}));
    lag_b <= 4'h2;
    pins(8'h07, 10);
    chk("code", 16'h0514, error_code_o);
    pins(8'h37, 4);
    chk("amp_off", 16'h0001, 16'(amp_off_o));
    lag_b <= 4'h0;
    clr();
    pins(8'h17, 0);
    pins(8'h37, 12);
    chk("valid", '0, 16'(error_valid_o));
    pins(8'h17, WIN + 12);
    chk("code", 16'h0515, error_code_o);
    chk("valid", 16'h0001, 16'(error_valid_o));
    pins(8'h37, 4);
    clr();
    wrap_up();
  end
endmodule : dio_top_tb

bind dio_top dio_top_monitor #(.SOF_WINDOW_CYC(SOF_WINDOW_CYC)) dio_top_monitor_i (.*);
